// File: timer_irq_defines.vh
// Behaviour
// - each timer run bit: write 1 starts its counter, 0 stops it.
// - each timer clear bit: write 1 clears its count, 0 has no effect.
// - timer clock select 00=100 kHz, 01=10 kHz, 10=2 kHz, 11=1 kHz.
// - timer 0 overflow bit reads 1 once the counter has overflowed.
// - timer 0 gate-close edge bit: 0 rising, 1 falling edge ends gating.
// - timer 0 mode bit 0 modulo, 1 gate; separate bit picks gate-open edge.
// - per external interrupt pin, edge bit 0 rising, 1 falling raises request.
// - pins d and e: block bit 1 stops the pin setting its request flag.
`ifndef TIMER_IRQ_DEFINES_VH
`define TIMER_IRQ_DEFINES_VH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define IDX_EDGE_HI      7'h1E
`define IDX_EDGE_LO      7'h1F
`define IDX_T2_CTRL      7'h29
`define IDX_T1_CTRL      7'h2A
`define IDX_T0_CTRL      7'h2B
`define IDX_T0_MODE      7'h2C
`define IDX_T0_COUNT     7'h30
`define IDX_T1_COUNT     7'h31
`define IDX_T2_COUNT     7'h32
`define IDX_IRQ_STATUS   7'h40
`define IDX_IRQ_ENABLE   7'h41
`define IDX_IRQ_CLEAR    7'h42

// ****************************************
// field positions
// ****************************************
`define CTRL_RUN_BIT     3
`define CTRL_CLEAR_BIT   2
`define CTRL_SEL_HI      1
`define CTRL_SEL_LO      0
`define MODE_OVF_BIT     3
`define MODE_CLOSE_BIT   2
`define MODE_OPEN_BIT    1
`define MODE_GATE_BIT    0
`define EHI_E_EDGE_BIT   3
`define EHI_E_BLOCK_BIT  2
`define EHI_D_EDGE_BIT   1
`define EHI_D_BLOCK_BIT  0
`define STAT_T0_BIT      5

// ****************************************
// reset values
// ****************************************
`define RST_CTRL         4'h0
`define RST_MODE         4'h0
`define RST_EDGE         4'h0
`define RST_IRQ          8'h00

// ****************************************
// timing
// ****************************************
`define CLK_HZ           10000000
`define TICK_A_HZ        100000
`define TICK_B_HZ        10000
`define TICK_C_HZ        2000
`define TICK_D_HZ        1000
// prescaler lengths in clock cycles for the four base clocks above
`define DIV_A_CYC        14'h0064
`define DIV_B_CYC        14'h03E8
`define DIV_C_CYC        14'h1388
`define DIV_D_CYC        14'h2710

`endif

// File: timer_channel.v
`timescale 1ns/1ns
module timer_channel #(
    parameter CNT_W = 8
) (
    // clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // control
    input  wire             tick,
    input  wire             run,
    input  wire             clear,
    input  wire             count_en,
    // status
    output reg  [CNT_W-1:0] count_r,
    output wire             overflow
);

// ****************************************
// counter
// ****************************************
assign overflow = tick && run && count_en && !clear && (&count_r);

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        count_r <= {CNT_W{1'b0}};
    end
    else if (clear)
    begin
        count_r <= {CNT_W{1'b0}};
    end
    else if (tick && run && count_en)
    begin
        count_r <= count_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end
end

endmodule // timer_channel

// File: timer_irq_ctrl.v
`timescale 1ns/1ns
`include "timer_irq_defines.vh"
module timer_irq_ctrl #(
    parameter        ADDR_W  = 12,
    parameter        CNT_W   = 8,
    parameter [13:0] DIV_A   = `DIV_A_CYC,
    parameter [13:0] DIV_B   = `DIV_B_CYC,
    parameter [13:0] DIV_C   = `DIV_C_CYC,
    parameter [13:0] DIV_D   = `DIV_D_CYC
) (
    // apb
    input  wire              pclk,
    input  wire              presetn,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    output wire              pready,
    output reg  [31:0]       prdata,
    output reg               pslverr,
    // external interrupt pins
    input  wire              ext_irq_a_pin,
    input  wire              ext_irq_b_pin,
    input  wire              ext_irq_c_pin,
    input  wire              ext_irq_d_pin,
    input  wire              ext_irq_e_pin,
    // timer 0 gate inputs
    input  wire              gate_open_pin,
    input  wire              gate_close_pin,
    // interrupt
    output wire              irq
);

// ****************************************
// register state
// ****************************************
localparam [3:0] RST_CTRL_V = `RST_CTRL;
reg              t0_overflow_flag_r;
reg              t0_gate_close_edge_r;
reg              t0_gate_open_edge_r;
reg              t0_count_mode_r;
reg  [3:0]       edge_hi_r;
reg  [2:0]       edge_lo_r;
reg  [7:0]       irq_status_r;
reg  [7:0]       irq_enable_r;
reg              gate_on_r;
reg  [31:0]      rdata_nxt;
reg              err_nxt;

wire             setup   = psel && !penable;
wire             wr_en   = psel && penable && pwrite;
wire             aligned = (paddr[1:0] == 2'b00);
wire [ADDR_W-3:0] idx    = paddr[ADDR_W-1:2];

// pready is tied high: every access completes in its first access cycle
assign pready = 1'b1;

// ****************************************
// pin synchroniser and edge detect
// ****************************************
wire [6:0] pin_raw = {gate_close_pin, gate_open_pin, ext_irq_e_pin, ext_irq_d_pin,
                      ext_irq_c_pin, ext_irq_b_pin, ext_irq_a_pin};
reg  [6:0] sync1_r;
reg  [6:0] sync2_r;
reg  [6:0] last_r;
wire [6:0] rise = sync2_r & ~last_r;
wire [6:0] fall = ~sync2_r & last_r;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        sync1_r <= 7'h00;
        sync2_r <= 7'h00;
        last_r  <= 7'h00;
    end
    else
    begin
        sync1_r <= pin_raw;
        sync2_r <= sync1_r;
        last_r  <= sync2_r;
    end
end

// edge select per pin, 0 rising and 1 falling
wire [4:0] irq_edge_sel = {edge_hi_r[`EHI_E_EDGE_BIT], edge_hi_r[`EHI_D_EDGE_BIT],
                           edge_lo_r[2], edge_lo_r[1], edge_lo_r[0]};
wire [4:0] irq_block    = {edge_hi_r[`EHI_E_BLOCK_BIT], edge_hi_r[`EHI_D_BLOCK_BIT],
                           3'b000};
wire [4:0] irq_event;

genvar gi;
generate
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : g_edge
        assign irq_event[gi] = (irq_edge_sel[gi] ? fall[gi] : rise[gi])
                               && !irq_block[gi];
    end
endgenerate

// ****************************************
// timer 0 gate window
// ****************************************
wire gate_open_ev  = t0_gate_open_edge_r ? fall[5] : rise[5];
wire gate_close_ev = t0_gate_close_edge_r ? fall[6] : rise[6];

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        gate_on_r <= 1'b0;
    end
    else if (!t0_count_mode_r || gate_close_ev)
    begin
        // a close edge wins over an open edge in the same cycle
        gate_on_r <= 1'b0;
    end
    else if (gate_open_ev)
    begin
        gate_on_r <= 1'b1;
    end
end

// ****************************************
// base clock prescalers
// ****************************************
wire [55:0] div_all = {DIV_D, DIV_C, DIV_B, DIV_A};
wire [3:0]  tick_all;

generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_pre
        reg  [13:0] pre_r;
        wire [13:0] div_v = div_all[gi*14 +: 14];
        assign tick_all[gi] = (pre_r == div_v - 14'h0001);
        always @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                pre_r <= 14'h0000;
            end
            else if (tick_all[gi])
            begin
                pre_r <= 14'h0000;
            end
            else
            begin
                pre_r <= pre_r + 14'h0001;
            end
        end
    end
endgenerate

// ****************************************
// timers
// ****************************************
wire [3*CNT_W-1:0] count_all;
wire [2:0]         clear_p;
wire [2:0]         ovf;
wire [2:0]         run_all;
wire [5:0]         sel_all;
wire [20:0]        ctrl_idx_all = {`IDX_T2_CTRL, `IDX_T1_CTRL, `IDX_T0_CTRL};

generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_tmr
        reg        run_r;
        reg  [1:0] sel_r;
        wire [6:0] my_idx = ctrl_idx_all[gi*7 +: 7];
        wire       hit    = aligned && (idx == {{(ADDR_W-9){1'b0}}, my_idx});
        assign clear_p[gi] = wr_en && hit && pwdata[`CTRL_CLEAR_BIT];

        always @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                run_r <= RST_CTRL_V[`CTRL_RUN_BIT];
                sel_r <= RST_CTRL_V[`CTRL_SEL_HI:`CTRL_SEL_LO];
            end
            else if (wr_en && hit)
            begin
                run_r <= pwdata[`CTRL_RUN_BIT];
                sel_r <= pwdata[`CTRL_SEL_HI:`CTRL_SEL_LO];
            end
        end
        assign run_all[gi]        = run_r;
        assign sel_all[2*gi +: 2] = sel_r;

        timer_channel #(
            .CNT_W    (CNT_W)
        ) u_chan (
            .pclk     (pclk),
            .presetn  (presetn),
            .tick     (tick_all[sel_r]),
            .run      (run_r),
            .clear    (clear_p[gi]),
            .count_en ((gi == 0) ? (!t0_count_mode_r || gate_on_r) : 1'b1),
            .count_r  (count_all[gi*CNT_W +: CNT_W]),
            .overflow (ovf[gi])
        );
    end
endgenerate

// ****************************************
// mode, edge and enable registers
// ****************************************
wire hit_mode = aligned && (idx == {{(ADDR_W-9){1'b0}}, `IDX_T0_MODE});
wire hit_ehi  = aligned && (idx == {{(ADDR_W-9){1'b0}}, `IDX_EDGE_HI});
wire hit_elo  = aligned && (idx == {{(ADDR_W-9){1'b0}}, `IDX_EDGE_LO});
wire hit_sta  = aligned && (idx == {{(ADDR_W-9){1'b0}}, `IDX_IRQ_STATUS});
wire hit_ena  = aligned && (idx == {{(ADDR_W-9){1'b0}}, `IDX_IRQ_ENABLE});
wire hit_clr  = aligned && (idx == {{(ADDR_W-9){1'b0}}, `IDX_IRQ_CLEAR});

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        t0_gate_close_edge_r <= 1'b0;
        t0_gate_open_edge_r  <= 1'b0;
        t0_count_mode_r      <= 1'b0;
        edge_hi_r            <= `RST_EDGE;
        edge_lo_r            <= 3'b000;
        irq_enable_r         <= `RST_IRQ;
    end
    else
    begin
        if (wr_en && hit_mode)
        begin
            t0_gate_close_edge_r <= pwdata[`MODE_CLOSE_BIT];
            t0_gate_open_edge_r  <= pwdata[`MODE_OPEN_BIT];
            t0_count_mode_r      <= pwdata[`MODE_GATE_BIT];
        end
        if (wr_en && hit_ehi)
        begin
            edge_hi_r <= pwdata[3:0];
        end
        if (wr_en && hit_elo)
        begin
            edge_lo_r <= pwdata[2:0];
        end
        if (wr_en && hit_ena)
        begin
            irq_enable_r <= pwdata[7:0];
        end
    end
end

// overflow flag: software writes 0 to clear it, a new overflow wins
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        t0_overflow_flag_r <= 1'b0;
    end
    else if (ovf[0])
    begin
        t0_overflow_flag_r <= 1'b1;
    end
    else if (wr_en && hit_mode && !pwdata[`MODE_OVF_BIT])
    begin
        t0_overflow_flag_r <= 1'b0;
    end
end

// ****************************************
// interrupt status
// ****************************************
// bits 4:0 pins a..e, bits 7:5 timer 0..2 overflow
wire [7:0] irq_set = {ovf[2], ovf[1], ovf[0], irq_event};
wire [7:0] irq_clr = (wr_en && hit_clr) ? pwdata[7:0] : 8'h00;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        irq_status_r <= `RST_IRQ;
    end
    else
    begin
        irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
    end
end

assign irq = |(irq_status_r & irq_enable_r);

// ****************************************
// read decode
// ****************************************
always @*
begin
    rdata_nxt = 32'h00000000;
    err_nxt   = 1'b0;
    if (!aligned)
        err_nxt = 1'b1;
    else if (hit_ehi)
        rdata_nxt[3:0] = edge_hi_r;
    else if (hit_elo)
        rdata_nxt[2:0] = edge_lo_r;
    else if (idx == {{(ADDR_W-9){1'b0}}, `IDX_T2_CTRL})
        rdata_nxt[3:0] = {run_all[2], 1'b0, sel_all[5:4]};
    else if (idx == {{(ADDR_W-9){1'b0}}, `IDX_T1_CTRL})
        rdata_nxt[3:0] = {run_all[1], 1'b0, sel_all[3:2]};
    else if (idx == {{(ADDR_W-9){1'b0}}, `IDX_T0_CTRL})
        rdata_nxt[3:0] = {run_all[0], 1'b0, sel_all[1:0]};
    else if (hit_mode)
        rdata_nxt[3:0] = {t0_overflow_flag_r, t0_gate_close_edge_r,
                          t0_gate_open_edge_r, t0_count_mode_r};
    else if (idx == {{(ADDR_W-9){1'b0}}, `IDX_T0_COUNT})
        rdata_nxt[CNT_W-1:0] = count_all[CNT_W-1:0];
    else if (idx == {{(ADDR_W-9){1'b0}}, `IDX_T1_COUNT})
        rdata_nxt[CNT_W-1:0] = count_all[2*CNT_W-1:CNT_W];
    else if (idx == {{(ADDR_W-9){1'b0}}, `IDX_T2_COUNT})
        rdata_nxt[CNT_W-1:0] = count_all[3*CNT_W-1:2*CNT_W];
    else if (hit_sta)
        rdata_nxt[7:0] = irq_status_r;
    else if (hit_ena)
        rdata_nxt[7:0] = irq_enable_r;
    else if (hit_clr)
        rdata_nxt = 32'h00000000; // write-only: reads as zero
    else
        err_nxt = 1'b1;
end

// read data is captured in the setup cycle so it comes from a flop
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        prdata  <= 32'h00000000;
        pslverr <= 1'b0;
    end
    else if (setup)
    begin
        prdata  <= pwrite ? 32'h00000000 : rdata_nxt;
        pslverr <= err_nxt;
    end
end

endmodule // timer_irq_ctrl

// File: timer_irq_chk_sva.sv
`timescale 1ns/1ns
module timer_irq_chk #(
    parameter ADDR_W = 12
) (
    // apb
    input wire              pclk,
    input wire              presetn,
    input wire              psel,
    input wire              penable,
    input wire              pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire              pready,
    input wire [31:0]       prdata,
    input wire              pslverr,
    // interrupt
    input wire              irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_setup = psel && !penable && !pwrite;

    property p_rdy; pready; endproperty
    a_rdy: assert property (p_rdy) else $error("pready low");
    property p_stand; psel && penable |=> $stable(prdata) && $stable(pslverr); endproperty
    a_stand: assert property (p_stand) else $error("read data moved in access");
    property p_unal; psel && !penable && paddr[1:0] != 2'h0 |=> pslverr; endproperty
    a_unal: assert property (p_unal) else $error("unaligned not refused");
    property p_mode; rd_setup && paddr == 12'h0B0 |=> !pslverr && prdata[31:4] == 28'h0; endproperty
    a_mode: assert property (p_mode) else $error("mode read bad");
    property p_ctrl; rd_setup && paddr == 12'h0AC |=> prdata[2] == 1'h0; endproperty
    a_ctrl: assert property (p_ctrl) else $error("clear bit read back");
    property p_lo; rd_setup && paddr == 12'h07C |=> prdata[31:3] == 29'h0; endproperty
    a_lo: assert property (p_lo) else $error("edge lo upper bits set");
    property p_hi; rd_setup && paddr == 12'h078 |=> prdata[31:4] == 28'h0; endproperty
    a_hi: assert property (p_hi) else $error("edge hi upper bits set");
    property p_fall; $fell(irq) |-> $past(psel && penable && pwrite); endproperty
    a_fall: assert property (p_fall) else $error("irq dropped without write");
endmodule // timer_irq_chk

bind timer_irq_ctrl timer_irq_chk #(.ADDR_W(ADDR_W)) u_timer_irq_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq)
);

// File: pin_model.sv
`timescale 1ns/1ns
// ******
// far-side pins: a..e, gate open, gate close
// ******
module pin_model (
    // clock
    input  wire       pclk,
    // requested levels
    input  wire [6:0] lvl,
    // pins
    output reg  [6:0] pin
);
    // pins move one edge late, unrelated to the bus transfer
    initial pin = 7'h00;
    always @(posedge pclk) pin <= lvl;
endmodule // pin_model

// File: tb_top.sv
`timescale 1ns/1ns
module tb_top;
    reg         pclk, presetn, psel, penable, pwrite;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rdv;
    reg  [6:0]  lvl;
    wire [6:0]  pin;
    wire [31:0] prdata;
    wire        pready, pslverr, irq;
    reg         erv;
    integer     error_cnt, n_tests, i;
    localparam [41:0] IXS = {7'h1E, 7'h1F, 7'h29, 7'h2A, 7'h2B, 7'h2C};
    localparam [23:0] MKS = 24'hF7BBB7;

    timer_irq_ctrl #(.DIV_A(14'h2), .DIV_B(14'h3), .DIV_C(14'h4), .DIV_D(14'h5)) u_timer_irq_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .ext_irq_a_pin(pin[0]), .ext_irq_b_pin(pin[1]), .ext_irq_c_pin(pin[2]),
        .ext_irq_d_pin(pin[3]), .ext_irq_e_pin(pin[4]), .gate_open_pin(pin[5]),
        .gate_close_pin(pin[6]), .irq(irq));
    pin_model u_pin_model (.pclk(pclk), .lvl(lvl), .pin(pin));

    // ******
    // bus, check and pin tasks
    // ******
    task close_out;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
            if (error_cnt == 0 && n_tests > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp)
            begin
                error_cnt = error_cnt + 1;
                $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task xfer(input w, input [6:0] idx, input [31:0] d);
        integer t;
        begin
            psel   <= 1'h1;
            pwrite <= w;
            paddr  <= {3'h0, idx, 2'h0};
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'h1;
            t = 0;
            @(posedge pclk);
            while (pready !== 1'h1 && t < 20)
            begin
                t = t + 1;
                @(posedge pclk);
            end
            if (t == 20)
            begin
                error_cnt = error_cnt + 1;
                close_out;
            end
            rdv = prdata;
            erv = pslverr;
            psel    <= 1'h0;
            penable <= 1'h0;
            @(posedge pclk);
        end
    endtask
    task wr(input [6:0] idx, input [31:0] d);
        xfer(1'h1, idx, d);
    endtask
    task rd(input [6:0] idx, input [31:0] exp);
        begin
            xfer(1'h0, idx, 32'h0);
            chk(rdv, exp);
        end
    endtask
    // three sync edges plus the model's own edge, with margin
    task setp(input [6:0] v);
        begin
            lvl <= v;
            repeat (6) @(posedge pclk);
        end
    endtask

    initial
    begin
        pclk = 1'h0;
        forever #50 pclk = ~pclk;
    end

    // ******
    // main sequence
    // ******
    initial
    begin
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        lvl = 7'h00;
        error_cnt = 0;
        n_tests = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        for (i = 0; i < 6; i = i + 1)
        begin
            rd(IXS[41-7*i -: 7], 32'h0);
            wr(IXS[41-7*i -: 7], 32'hF);
            rd(IXS[41-7*i -: 7], {28'h0, MKS[23-4*i -: 4]});
            wr(IXS[41-7*i -: 7], 32'h0);
        end
        xfer(1'h0, 7'h05, 32'h0);
        chk(erv, 1'h1);
        setp(7'h1F);
        rd(7'h40, 32'h1F);
        wr(7'h42, 32'hFF);
        setp(7'h00);
        rd(7'h40, 32'h0);
        wr(7'h1E, 32'hA);
        wr(7'h1F, 32'h7);
        setp(7'h1F);
        rd(7'h40, 32'h0);
        setp(7'h00);
        rd(7'h40, 32'h1F);
        wr(7'h42, 32'hFF);
        wr(7'h1E, 32'h5);
        wr(7'h1F, 32'h0);
        setp(7'h1F);
        rd(7'h40, 32'h07);
        setp(7'h00);
        wr(7'h41, 32'h1);
        chk(irq, 1'h1);
        wr(7'h41, 32'h0);
        chk(irq, 1'h0);
        wr(7'h41, 32'h1);
        wr(7'h42, 32'hFF);
        chk(irq, 1'h0);
        wr(7'h41, 32'h0);
        // about 63 cycles between start and stop write edges; prescaler phase gives +-1
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(7'h2A, 32'hC | i);
            repeat (60) @(posedge pclk);
            wr(7'h2A, i);
            xfer(1'h0, 7'h31, 32'h0);
            chk(rdv >= 63 / (i + 2) - 1 && rdv <= 63 / (i + 2) + 1, 1'h1);
            rd(7'h31, rdv);
        end
        wr(7'h2A, 32'h4);
        rd(7'h31, 32'h0);
        wr(7'h2B, 32'hC);
        repeat (560) @(posedge pclk);
        wr(7'h2B, 32'h0);
        rd(7'h2C, 32'h8);
        rd(7'h40, 32'h20);
        wr(7'h2C, 32'h0);
        rd(7'h2C, 32'h0);
        wr(7'h42, 32'hFF);
        wr(7'h2C, 32'h5);
        wr(7'h2B, 32'hC);
        repeat (20) @(posedge pclk);
        rd(7'h30, 32'h0);
        setp(7'h20);
        repeat (20) @(posedge pclk);
        setp(7'h60);
        repeat (20) @(posedge pclk);
        setp(7'h20);
        xfer(1'h0, 7'h30, 32'h0);
        chk(rdv > 20, 1'h1);
        repeat (10) @(posedge pclk);
        rd(7'h30, rdv);
        wr(7'h2C, 32'h1);
        wr(7'h2B, 32'hC);
        setp(7'h00);
        setp(7'h20);
        setp(7'h60);
        repeat (20) @(posedge pclk);
        xfer(1'h0, 7'h30, 32'h0);
        chk(rdv >= 2 && rdv <= 4, 1'h1);
        wr(7'h29, 32'hC);
        repeat (60) @(posedge pclk);
        wr(7'h29, 32'h0);
        xfer(1'h0, 7'h32, 32'h0);
        chk(rdv >= 30 && rdv <= 32, 1'h1);
        close_out;
    end
endmodule // tb_top
